// File: core/bcd_arith_unit.sv
// Packed-BCD subtract, multiply and divide unit with carry, zero and fault flags
//
// Function
// [RQ1] Single subtract forms 10000 plus left operand minus taken-away minus carry.
// [RQ2] Positive single difference: drop fifth digit, keep four in destination.
// [RQ3] Negative single difference: store ten's complement and set carry.
// [RQ4] Double subtract: 8-digit left minus 8-digit taken-away minus carry, two words.
// [RQ5] Negative double difference: ten's complement over both words, carry set.
// [RQ6] Double subtract carry on exactly when the result is negative.
// [RQ7] Execution condition off: nothing executes, no word or flag changes.
// [RQ8] Double subtract faults on any non-BCD nibble in four operand words.
// [RQ9] Every operation faults on a bad indirect data-memory reference.
// [RQ10] Zero flag on exactly when the complete result is zero.
// [RQ11] Single multiply: 8-digit product, low four digits first word.
// [RQ12] Both multiplies set carry when the product generates a carry.
// [RQ13] Double multiply: 8 by 8 digits, 16-digit product in four words.
// [RQ14] Double multiply faults on any non-BCD multiplicand or multiplier word.
// [RQ15] Single divide: quotient to first word, remainder to next word.
// [RQ16] Single divide skipped without side effects when condition is off.
// [RQ17] Sequencer keeps both single divide destination words in one area.
// [RQ18] Single divide faults when dividend or divisor is not BCD.
// [RQ19] Double divide: quotient in words one and two, remainder three, four.
// [RQ20] Double divide faults on zero divisor or any non-BCD word.
// [RQ21] Double divide validity covers both dividend and both divisor words.
// [RQ22] A faulting execution leaves every destination word unchanged.
`timescale 1ns/1ns
module bcd_arith_unit
    import bcd_unit_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic req_valid_i,
    input wire req_s req_i,
    input wire logic carry_clear_i,
    output logic req_ready_o,
    output logic done_o,
    output resp_s resp_o,
    output logic carry_flag_o,
    output logic zero_flag_o,
    output logic fault_flag_o
);

    typedef enum logic [2:0] {
        st_idle = 3'b001,
        st_mul = 3'b010,
        st_div = 3'b100
    } state_e;

    // Decimal add of sixteen digits, returns {carry, sum}
    function automatic logic [64:0] bcd_add(input logic [63:0] x, input logic [63:0] y,
                                            input logic cin);
        logic [4:0] s;
        logic c;
        logic [63:0] r;
        c = cin;
        r = '0;
        for (int i = 0; i < NDIG; i++)
        begin
            s = {1'b0, x[i*DIGIT_W +: DIGIT_W]} + {1'b0, y[i*DIGIT_W +: DIGIT_W]} + 5'(c);
            c = (s > {1'b0, DIGIT_MAX});
            if (c)
            begin
                s = s + {1'b0, DIGIT_ADJ};
            end
            r[i*DIGIT_W +: DIGIT_W] = s[DIGIT_W-1:0];
        end
        return {c, r};
    endfunction : bcd_add

    // Decimal x - y - bin via nines complement, returns {borrow, difference}
    function automatic logic [64:0] bcd_sub(input logic [63:0] x, input logic [63:0] y,
                                            input logic bin);
        logic [63:0] n;
        logic [64:0] t;
        n = '0;
        for (int i = 0; i < NDIG; i++)
        begin
            n[i*DIGIT_W +: DIGIT_W] = DIGIT_MAX - y[i*DIGIT_W +: DIGIT_W];
        end
        t = bcd_add(x, n, ~bin);
        return {~t[WIDE_W], t[WIDE_W-1:0]};
    endfunction : bcd_sub

    // True when every nibble is a legal decimal digit
    function automatic logic bcd_ok(input logic [63:0] x);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < NDIG; i++)
        begin
            if (x[i*DIGIT_W +: DIGIT_W] > DIGIT_MAX)
            begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction : bcd_ok

    state_e state_r;
    op_e op_r;
    logic [63:0] acc_r;
    logic [63:0] opa_r;
    logic [31:0] opb_r;
    logic [31:0] quo_r;
    logic [3:0] cnt_r;
    logic phase_r;
    logic mul_cy_r;
    resp_s resp_r;
    logic done_r;
    logic carry_r;
    logic zero_r;
    logic fault_r;

    logic take_w;
    logic single_w;
    logic is_div_w;
    logic [63:0] wide_a_w;
    logic [63:0] wide_b_w;
    logic bad_w;
    logic [64:0] sub_w;
    logic [64:0] madd_w;
    logic [64:0] dsub_w;
    logic [3:0] top_w;
    logic mul_last_w;
    logic div_last_w;

    logic fin_w;
    logic [63:0] fin_words;
    logic [3:0] fin_mask;
    logic fin_upd;
    logic fin_carry_upd;
    logic fin_carry;
    logic fin_zero;
    logic fin_fault;

    // Operand assembly; single-word ops see their upper words as zero
    assign req_ready_o = (state_r == st_idle);
    assign take_w = req_valid_i && req_ready_o;
    assign single_w = (req_i.op == bcd_minus_single) || (req_i.op == bcd_times_single) ||
                      (req_i.op == bcd_quotient_single);
    assign is_div_w = (req_i.op == bcd_quotient_single) || (req_i.op == bcd_quotient_double);
    assign wide_a_w = single_w ? WIDE_W'(req_i.a_lo) : WIDE_W'({req_i.a_hi, req_i.a_lo});
    assign wide_b_w = single_w ? WIDE_W'(req_i.b_lo) : WIDE_W'({req_i.b_hi, req_i.b_lo});

    // Fault check covers every operand word the operation reads
    assign bad_w = req_i.ind_fault ||                                     // [RQ9]
                   !bcd_ok(wide_a_w) || !bcd_ok(wide_b_w) ||              // [RQ8] [RQ14] [RQ18] [RQ21]
                   (is_div_w && (wide_b_w == '0));                        // [RQ20]

    // Sixteen-digit subtract; wraps to the ten's complement when negative
    assign sub_w = bcd_sub(wide_a_w, wide_b_w, carry_r);                  // [RQ1] [RQ4]
    assign madd_w = bcd_add(acc_r, opa_r, 1'b0);
    assign dsub_w = bcd_sub(acc_r, opa_r, 1'b0);
    assign top_w = opb_r[HALF_W-1 -: DIGIT_W];
    assign mul_last_w = (top_w == DIGIT_ZERO) && (cnt_r == CNT_LAST);
    assign div_last_w = phase_r && dsub_w[WIDE_W] && (cnt_r == CNT_LAST);

    // Completion: what is written and which flags move
    always_comb
    begin
        fin_w = 1'b0;
        fin_words = resp_r.words;
        fin_mask = MASK_NONE;
        fin_upd = 1'b0;
        fin_carry_upd = 1'b0;
        fin_carry = carry_r;
        fin_zero = zero_r;
        fin_fault = fault_r;
        unique case (state_r)
            st_idle:
            begin
                if (take_w && !req_i.exec_cond)
                begin
                    fin_w = 1'b1;                                         // [RQ7] [RQ16]
                end
                else if (take_w && bad_w)
                begin
                    fin_w = 1'b1;                                         // [RQ22]
                    fin_upd = 1'b1;
                    fin_fault = 1'b1;
                end
                else if (take_w && (req_i.op == bcd_minus_single))
                begin
                    fin_w = 1'b1;
                    fin_upd = 1'b1;
                    fin_fault = 1'b0;
                    fin_words = WIDE_W'(sub_w[WORD_W-1:0]);              // [RQ2] [RQ3]
                    fin_mask = MASK_ONE;
                    fin_carry_upd = 1'b1;
                    fin_carry = sub_w[WIDE_W];                            // [RQ3]
                    fin_zero = (sub_w[WORD_W-1:0] == '0);                 // [RQ10]
                end
                else if (take_w && (req_i.op == bcd_minus_double))
                begin
                    fin_w = 1'b1;
                    fin_upd = 1'b1;
                    fin_fault = 1'b0;
                    fin_words = WIDE_W'(sub_w[HALF_W-1:0]);              // [RQ4] [RQ5]
                    fin_mask = MASK_TWO;
                    fin_carry_upd = 1'b1;
                    fin_carry = sub_w[WIDE_W];                            // [RQ5] [RQ6]
                    fin_zero = (sub_w[HALF_W-1:0] == '0);                 // [RQ10]
                end
            end
            st_mul:
            begin
                if (mul_last_w)
                begin
                    fin_w = 1'b1;
                    fin_upd = 1'b1;
                    fin_fault = 1'b0;
                    fin_words = acc_r;                                    // [RQ11] [RQ13]
                    fin_mask = (op_r == bcd_times_single) ? MASK_TWO : MASK_ALL;
                    fin_carry_upd = 1'b1;
                    fin_carry = mul_cy_r;                                 // [RQ12]
                    fin_zero = (acc_r == '0);                             // [RQ10]
                end
            end
            st_div:
            begin
                if (div_last_w)
                begin
                    fin_w = 1'b1;
                    fin_upd = 1'b1;
                    fin_fault = 1'b0;
                    if (op_r == bcd_quotient_single)
                    begin
                        fin_words = WIDE_W'({acc_r[WORD_W-1:0], quo_r[WORD_W-1:0]}); // [RQ15]
                        fin_mask = MASK_TWO;
                    end
                    else
                    begin
                        fin_words = {acc_r[HALF_W-1:0], quo_r};          // [RQ19]
                        fin_mask = MASK_ALL;
                    end
                    fin_zero = (quo_r == '0) && (acc_r == '0);            // [RQ10]
                end
            end
            default:
            begin
                fin_w = 1'b0;
            end
        endcase
    end

    // Sequencing and the digit-serial multiply and divide loops
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            state_r <= st_idle;
            op_r <= bcd_minus_single;
            acc_r <= '0;
            opa_r <= '0;
            opb_r <= '0;
            quo_r <= '0;
            cnt_r <= CNT_LAST;
            phase_r <= 1'b0;
            mul_cy_r <= 1'b0;
        end
        else
        begin
            unique case (state_r)
                st_idle:
                begin
                    if (take_w && req_i.exec_cond && !bad_w && !fin_w)
                    begin
                        op_r <= req_i.op;
                        acc_r <= '0;
                        quo_r <= '0;
                        cnt_r <= CNT_FIRST;
                        phase_r <= 1'b0;
                        mul_cy_r <= 1'b0;
                        if (is_div_w)
                        begin
                            opa_r <= wide_b_w;
                            opb_r <= wide_a_w[HALF_W-1:0];
                            state_r <= st_div;
                        end
                        else
                        begin
                            opa_r <= wide_a_w;
                            opb_r <= wide_b_w[HALF_W-1:0];
                            state_r <= st_mul;
                        end
                    end
                end
                st_mul:
                begin
                    // Add the multiplicand once per unit of the top digit, then shift
                    if (top_w != DIGIT_ZERO)
                    begin
                        acc_r <= madd_w[WIDE_W-1:0];                      // [RQ11] [RQ13]
                        mul_cy_r <= mul_cy_r | madd_w[WIDE_W];            // [RQ12]
                        opb_r[HALF_W-1 -: DIGIT_W] <= top_w - DIGIT_ONE;
                    end
                    else if (cnt_r == CNT_LAST)
                    begin
                        state_r <= st_idle;
                    end
                    else
                    begin
                        acc_r <= acc_r << DIGIT_W;
                        opb_r <= opb_r << DIGIT_W;
                        cnt_r <= cnt_r - DIGIT_ONE;
                    end
                end
                st_div:
                begin
                    // Restoring decimal division: bring down a digit, then subtract
                    if (!phase_r)
                    begin
                        acc_r <= {acc_r[WIDE_W-DIGIT_W-1:0], top_w};
                        opb_r <= opb_r << DIGIT_W;
                        quo_r <= quo_r << DIGIT_W;
                        phase_r <= 1'b1;
                    end
                    else if (!dsub_w[WIDE_W])
                    begin
                        acc_r <= dsub_w[WIDE_W-1:0];                      // [RQ15] [RQ19]
                        quo_r[DIGIT_W-1:0] <= quo_r[DIGIT_W-1:0] + DIGIT_ONE;
                    end
                    else if (cnt_r == CNT_LAST)
                    begin
                        state_r <= st_idle;
                    end
                    else
                    begin
                        cnt_r <= cnt_r - DIGIT_ONE;
                        phase_r <= 1'b0;
                    end
                end
                default:
                begin
                    state_r <= st_idle;
                end
            endcase
        end
    end

    // Result words and completion pulse; a skipped or faulted run writes nothing
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            resp_r <= '0;
            done_r <= 1'b0;
        end
        else
        begin
            done_r <= fin_w;
            if (fin_w)
            begin
                resp_r.words <= fin_words;
                resp_r.wr_mask <= fin_mask;                               // [RQ22]
            end
        end
    end

    // Carry: an update from an operation wins over a same-cycle clear
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            carry_r <= 1'b0;
        end
        else if (fin_carry_upd)
        begin
            carry_r <= fin_carry;
        end
        else if (carry_clear_i)
        begin
            carry_r <= 1'b0;
        end
    end

    // Zero and fault only move when an operation really executes
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            zero_r <= 1'b0;
            fault_r <= 1'b0;
        end
        else if (fin_upd)
        begin
            zero_r <= fin_zero;
            fault_r <= fin_fault;
        end
    end

    assign done_o = done_r;
    assign resp_o = resp_r;
    assign carry_flag_o = carry_r;
    assign zero_flag_o = zero_r;
    assign fault_flag_o = fault_r;

    // Checks
    localparam int MUL_BOUND = 90;
    localparam int DIV_BOUND = 100;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    logic go_w;
    assign go_w = take_w && req_i.exec_cond && !bad_w;

    skip_no_effect_a: assert property (take_w && !req_i.exec_cond |=>    // [RQ7]
        done_o && (resp_o.wr_mask == MASK_NONE) && $stable(carry_flag_o) &&
        $stable(zero_flag_o) && $stable(fault_flag_o))
        else $error("skipped operation changed state");

    fault_no_write_a: assert property (take_w && req_i.exec_cond && bad_w |=> // [RQ22]
        done_o && fault_flag_o && (resp_o.wr_mask == MASK_NONE))
        else $error("faulted operation wrote or missed fault");

    ind_fault_a: assert property (take_w && req_i.exec_cond && req_i.ind_fault |=> // [RQ9]
        fault_flag_o)
        else $error("indirect fault not flagged");

    div_zero_a: assert property (take_w && req_i.exec_cond &&            // [RQ20]
        (req_i.op == bcd_quotient_double) && (req_i.b_lo == '0) && (req_i.b_hi == '0) |=>
        fault_flag_o && done_o)
        else $error("zero divisor not flagged");

    sub_single_val_a: assert property (go_w && (req_i.op == bcd_minus_single) |=> // [RQ1]
        done_o && (bcd_add(WIDE_W'(resp_o.words[WORD_W-1:0]), WIDE_W'($past(req_i.b_lo)),
        $past(carry_flag_o)) & WIDE_W'(16'hffff)) == WIDE_W'($past(req_i.a_lo)))
        else $error("single difference wrong");

    sub_double_cy_a: assert property (go_w && (req_i.op == bcd_minus_double) |=> // [RQ6]
        carry_flag_o == (($past({req_i.a_hi, req_i.a_lo}) < $past({req_i.b_hi, req_i.b_lo})) ||
        (($past({req_i.a_hi, req_i.a_lo}) == $past({req_i.b_hi, req_i.b_lo})) &&
        $past(carry_flag_o))))
        else $error("double subtract carry wrong");

    mul_done_a: assert property (go_w && ((req_i.op == bcd_times_single) ||  // [RQ13]
        (req_i.op == bcd_times_double)) |-> ##[1:MUL_BOUND] done_o)
        else $error("multiply did not finish");

    div_done_a: assert property (go_w && is_div_w |-> ##[1:DIV_BOUND] done_o) // [RQ19]
        else $error("divide did not finish");

    zero_flag_a: assert property (done_o && !fault_flag_o &&             // [RQ10]
        (resp_o.wr_mask == MASK_ALL) |-> zero_flag_o == (resp_o.words == '0))
        else $error("zero flag disagrees with result");

    busy_ready_a: assert property (state_r != st_idle |-> !req_ready_o && !done_o) // [RQ11]
        else $error("busy unit accepted or finished");

    neg_sub_c: cover property (go_w && (req_i.op == bcd_minus_single) ##1 carry_flag_o);
    mul_dbl_c: cover property (go_w && (req_i.op == bcd_times_double) ##[1:MUL_BOUND] done_o);
    div_dbl_c: cover property (go_w && (req_i.op == bcd_quotient_double) ##[1:DIV_BOUND] done_o);
    fault_c: cover property (take_w && req_i.exec_cond && bad_w);

endmodule : bcd_arith_unit

// File: core/bcd_unit_pkg.sv
// Shared constants, opcodes and carriers for the packed-BCD arithmetic unit
package bcd_unit_pkg;

    // Word and digit geometry
    localparam int WORD_W = 16;
    localparam int DIGIT_W = 4;
    localparam int WIDE_W = 64;
    localparam int NDIG = 16;
    localparam int HALF_W = 32;

    // Digit arithmetic
    localparam logic [3:0] DIGIT_MAX = 4'h9;
    localparam logic [3:0] DIGIT_ADJ = 4'h6;
    localparam logic [3:0] DIGIT_ONE = 4'h1;
    localparam logic [3:0] DIGIT_ZERO = 4'h0;

    // Digit loop counter: eight digits, counted down to zero
    localparam logic [3:0] CNT_FIRST = 4'h7;
    localparam logic [3:0] CNT_LAST = 4'h0;

    // Destination word write masks (bit n enables destination word n)
    localparam logic [3:0] MASK_NONE = 4'h0;
    localparam logic [3:0] MASK_ONE = 4'h1;
    localparam logic [3:0] MASK_TWO = 4'h3;
    localparam logic [3:0] MASK_ALL = 4'hf;

    // Operations
    typedef enum logic [2:0] {
        bcd_minus_single = 3'h0,
        bcd_minus_double = 3'h1,
        bcd_times_single = 3'h2,
        bcd_times_double = 3'h3,
        bcd_quotient_single = 3'h4,
        bcd_quotient_double = 3'h5
    } op_e;

    // Request from the instruction sequencer
    typedef struct packed {
        op_e op;
        logic exec_cond;
        logic ind_fault;
        logic [15:0] b_hi;
        logic [15:0] b_lo;
        logic [15:0] a_hi;
        logic [15:0] a_lo;
    } req_s;

    // Result words {w3, w2, w1, w0} and their write enables
    typedef struct packed {
        logic [3:0] wr_mask;
        logic [63:0] words;
    } resp_s;

endpackage : bcd_unit_pkg

// File: sim/seq_model.sv
// Sequencer model that offers requests and a carry clear to the unit
`timescale 1ns/1ns
module seq_model
    import bcd_unit_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic ready_i,
    output logic req_valid_o,
    output req_s req_o,
    output logic carry_clear_o
);
    // Quiet at time zero so the unit never sees an unknown request
    initial
    begin
        req_valid_o = 1'b0;
        req_o = '0;
        carry_clear_o = 1'b0;
    end

    // One request held until taken; gap idles to act as a slow sequencer.
    // Quotient and remainder leave as one response, so both land in one area
    task automatic issue(input req_s r, input logic clr, input int gap);
        repeat (gap + 1) @(posedge ref_clk_i);
        #2;
        if (clr)
        begin
            carry_clear_o = 1'b1;
            @(posedge ref_clk_i);
            #2;
            carry_clear_o = 1'b0;
        end
        req_o = r;
        req_valid_o = 1'b1;
        while (ready_i !== 1'b1 || rst_i !== 1'b0)
        begin
            @(posedge ref_clk_i);
            #2;
        end
        @(posedge ref_clk_i);
        #2;
        // Released lines show the inverse, so stale data never passes for valid
        req_valid_o = 1'b0;
        req_o = ~r;
    endtask : issue
endmodule : seq_model

// File: sim/bcd_sub_mul_div_unit_tb_top.sv
// Self-checking bench for the packed-BCD arithmetic unit
`timescale 1ns/1ns
module bcd_sub_mul_div_unit_tb_top
    import bcd_unit_pkg::*;
;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    wire logic req_valid;
    wire logic carry_clear;
    wire req_s req;
    logic ready, done, cy, zf, ff;
    resp_s resp;
    int fails = 0;
    int total_checks = 0;
    logic [31:0] seed = 32'd18715;
    logic [3:0] e_mask = 4'h0;
    logic [63:0] e_w;
    logic e_cy = 1'b0;
    logic e_zero = 1'b0;
    logic e_fault = 1'b0;

    // Free-running 20 MHz clock
    always #25 ref_clk_i = ~ref_clk_i;

    bcd_arith_unit i_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .req_valid_i(req_valid),
        .req_i(req), .carry_clear_i(carry_clear), .req_ready_o(ready), .done_o(done),
        .resp_o(resp), .carry_flag_o(cy), .zero_flag_o(zf), .fault_flag_o(ff));
    seq_model i_seq (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ready_i(ready),
        .req_valid_o(req_valid), .req_o(req), .carry_clear_o(carry_clear));

    // Xorshift source, fixed start so runs repeat
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    // Mostly legal BCD word, now and then one bad digit
    function automatic logic [15:0] rword();
        logic [15:0] w;
        for (int i = 0; i < 4; i++) w[i*4+:4] = 4'(rnd() % 10);
        if (rnd() % 24 == 0) w[7:4] = 4'hb;
        return w;
    endfunction : rword

    function automatic req_s mk(input op_e op, input logic ex, input logic ind,
        input logic [31:0] a, input logic [31:0] b);
        return '{op, ex, ind, b[31:16], b[15:0], a[31:16], a[15:0]};
    endfunction : mk

    function automatic longint b2i(input logic [63:0] v);
        longint s;
        s = 0;
        for (int i = 15; i >= 0; i--) s = s * 10 + v[i*4+:4];
        return s;
    endfunction : b2i

    function automatic logic [63:0] i2b(input longint x);
        logic [63:0] v;
        for (int i = 0; i < 16; i++)
        begin
            v[i*4+:4] = 4'(x % 10);
            x = x / 10;
        end
        return v;
    endfunction : i2b

    function automatic logic ok(input logic [31:0] v);
        for (int i = 0; i < 8; i++) if (v[i*4+:4] > 4'h9) return 1'b0;
        return 1'b1;
    endfunction : ok

    // Reference arithmetic; upper words of single ops are ignored
    task automatic expect_op(input req_s r);
        logic dbl, bad;
        longint a, b, p, m;
        dbl = r.op inside {bcd_minus_double, bcd_times_double, bcd_quotient_double};
        a = b2i(dbl ? {32'h0, r.a_hi, r.a_lo} : {48'h0, r.a_lo});
        b = b2i(dbl ? {32'h0, r.b_hi, r.b_lo} : {48'h0, r.b_lo});
        bad = r.ind_fault || !ok({r.a_lo, r.b_lo}) || (dbl && !ok({r.a_hi, r.b_hi}));
        if (r.op inside {bcd_quotient_single, bcd_quotient_double} && b == 0) bad = 1'b1;
        e_mask = 4'h0;
        if (!r.exec_cond) return;
        e_fault = bad;
        if (bad) return;
        m = dbl ? 100000000 : 10000;
        if (r.op inside {bcd_minus_single, bcd_minus_double})
        begin
            p = m + a - b - e_cy;
            e_cy = p < m;
            p = p % m;
            e_mask = dbl ? 4'h3 : 4'h1;
        end
        else if (r.op inside {bcd_times_single, bcd_times_double})
        begin
            p = a * b;
            e_cy = 1'b0;
            e_mask = dbl ? 4'hf : 4'h3;
        end
        else
        begin
            p = a;
            e_mask = dbl ? 4'hf : 4'h3;
        end
        e_w = (e_mask == 4'h3 && p == a) ? i2b(a / b) | (i2b(a % b) << 16) : i2b(p);
        if (dbl && r.op == bcd_quotient_double) e_w = i2b(a / b) | (i2b(a % b) << 32);
        e_zero = p == 0;
    endtask : expect_op

    task automatic chk(input logic c, input string msg);
        total_checks++;
        if (c !== 1'b1)
        begin
            fails++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask : chk

    // One complete operation: offer, wait bounded, compare, done drops
    task automatic run(input req_s r, input logic clr, input int gap);
        int n;
        n = 0;
        if (clr) e_cy = 1'b0;
        expect_op(r);
        i_seq.issue(r, clr, gap);
        while (done !== 1'b1 && n < 120)
        begin
            @(posedge ref_clk_i);
            #2;
            n++;
        end
        chk(done, "no completion");
        chk(resp.wr_mask === e_mask, "write mask");
        for (int i = 0; i < 4; i++)
            if (e_mask[i]) chk(resp.words[i*16+:16] === e_w[i*16+:16], "word");
        chk(cy === e_cy, "carry");
        chk(zf === e_zero, "zero");
        chk(ff === e_fault, "fault");
        @(posedge ref_clk_i);
        #2;
        chk(done === 1'b0, "done held");
    endtask : run

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : report_and_stop

    // Corner cases first, then random traffic
    initial
    begin
        repeat (4) @(posedge ref_clk_i);
        #2;
        rst_i = 1'b0;
        chk(ready === 1'b1 && cy === 1'b0 && zf === 1'b0 && ff === 1'b0, "reset");
        run(mk(bcd_minus_single, 1, 0, 32'h1029, 32'h3452), 1, 0);
        run(mk(bcd_minus_single, 1, 0, 32'h5000, 32'h1000), 0, 0);
        run(mk(bcd_minus_single, 1, 0, 32'h0, 32'h7577), 1, 1);
        run(mk(bcd_minus_double, 1, 0, 32'h12345678, 32'h12345678), 1, 0);
        run(mk(bcd_minus_double, 1, 0, 32'h0, 32'h1), 0, 0);
        run(mk(bcd_minus_double, 1, 0, 32'h5, 32'h00c00001), 0, 0);
        run(mk(bcd_times_single, 1, 0, 32'h3356, 32'h0025), 0, 2);
        run(mk(bcd_times_double, 1, 0, 32'h99999999, 32'h99999999), 0, 0);
        run(mk(bcd_times_double, 1, 0, 32'h0a000000, 32'h3), 0, 0);
        run(mk(bcd_quotient_double, 1, 0, 32'h5, 32'h0), 0, 0);
        run(mk(bcd_quotient_single, 0, 0, 32'h9999, 32'h7), 0, 0);
        run(mk(bcd_quotient_single, 1, 0, 32'h9999, 32'h7), 0, 0);
        run(mk(bcd_quotient_single, 1, 0, 32'h99e9, 32'h7), 0, 0);
        run(mk(bcd_quotient_double, 1, 0, 32'h1b000000, 32'h7), 0, 0);
        run(mk(bcd_quotient_double, 1, 0, 32'h98765432, 32'h1234), 0, 0);
        run(mk(bcd_minus_single, 1, 1, 32'h5, 32'h1), 0, 0);
        repeat (300)
            run(mk(op_e'(3'(rnd() % 6)), rnd() % 8 != 0, rnd() % 16 == 0,
                {rword(), rword()}, {rword(), rword()}), rnd() % 4 == 0, int'(rnd() % 3));
        report_and_stop();
    end

    // Hang guard, well past 316 operations of at most about 100 cycles
    initial
    begin
        #(60000 * 50);
        fails++;
        $display("ERROR %0t watchdog expired", $time);
        report_and_stop();
    end
endmodule : bcd_sub_mul_div_unit_tb_top
